// >>> core/irke_encoder.sv
/*
  Infrared remote keyboard encoder: matrix scan, debounce, column interlock,
  biphase framing with pre-signal, carrier keying and supply switch drive.
  Assumes clk_in is the oscillator clock and rows read high when closed.
*/
`timescale 1ns/100ps
`include "irke_defines.svh"

module irke_encoder #(
  parameter bit START_BIT   = `IRKE_START_BIT,  // [RULE_08]
  parameter bit LSB_FIRST   = 1'b0,             // [RULE_16]
  parameter bit BIPH_INVERT = 1'b0,             // [RULE_16]
  parameter int PRE_SLOTS   = 1,                // [RULE_16]
  parameter int DEBOUNCE_CYC = `IRKE_DEBOUNCE_CYC,
  parameter int REPEAT_CYC   = `IRKE_REPEAT_CYC,
  parameter int HALF_CYC     = `IRKE_HALF_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       ce_in,
  input  wire logic [7:0] row_in,
  output logic      [3:0] column_drive_out,
  output logic            infrared_drive_out,
  output logic            infrared_drive_oe_out,
  output logic            supply_switch_drive_out,
  output logic            oscillator_out
);

  // ----------------------------------------------------------------
  // Key table
  // ----------------------------------------------------------------
  // Basic: code = {0, row, col}; pairs on one column: {1, lower row, col}
  function automatic logic [5:0] key_code(input logic [1:0] col, input logic [7:0] rows);
    logic [2:0] first;
    logic [3:0] cnt;
    logic [5:0] code;
    first = 3'h0;
    cnt   = 4'h0;
    for (int r = 7; r >= 0; r--) begin
      if (rows[r]) begin
        first = 3'(r);
        cnt   = cnt + 4'h1;
      end
    end
    if (cnt == 4'h1) begin
      code = {1'b0, first, col};                 // [RULE_15]
    end else begin
      code = {1'b1, first, col};                 // [RULE_02] [RULE_15]
    end
    if (code == `IRKE_RSVD_CODE || code == `IRKE_END_CODE) begin
      code = `IRKE_END_CODE;                     // [RULE_06]
    end
    return code;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  irke_pkg::irke_state_e state_ff, nxt_state;
  irke_pkg::irke_frame_s frm_ff, nxt_frm;
  logic [16:0] tmr_ff, nxt_tmr;
  logic [16:0] rep_ff, nxt_rep;
  logic [4:0]  slot_ff, nxt_slot;
  logic [1:0]  col_ff, nxt_col;
  logic [3:0]  hit_ff, nxt_hit;
  logic        car_ff, nxt_car;
  logic        ir_ff, nxt_ir;
  logic        oe_ff, nxt_oe;
  logic        sup_ff, nxt_sup;
  logic [3:0]  cdrv_ff, nxt_cdrv;

  logic       any_row;
  logic       slot_bit;
  logic [6:0] word;
  logic [2:0] bidx;
  logic       on_phase;

  assign any_row = |row_in;
  assign word    = {START_BIT, frm_ff.code};     // [RULE_07]

  always_comb begin
    bidx = 3'h0;
    slot_bit = 1'b0;
    on_phase = 1'b0;
    if (slot_ff < 5'(2 * PRE_SLOTS)) begin
      on_phase = (slot_ff < 5'(PRE_SLOTS));      // [RULE_11]
    end else begin
      bidx = 3'((slot_ff - 5'(2 * PRE_SLOTS)) >> 1);
      if (bidx == 3'h0) begin
        slot_bit = word[6];
      end else if (LSB_FIRST) begin
        slot_bit = word[bidx - 3'h1];
      end else begin
        slot_bit = word[3'h6 - bidx];            // [RULE_16]
      end
      // Biphase: first half carries the complement, second half the bit
      on_phase = slot_ff[0] ^ slot_bit ^ BIPH_INVERT ^ 1'b1; // [RULE_07]
    end
  end

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_frm   = frm_ff;
    nxt_tmr   = tmr_ff;
    nxt_rep   = rep_ff;
    nxt_slot  = slot_ff;
    nxt_col   = col_ff;
    nxt_hit   = hit_ff;
    nxt_car   = 1'b0;
    nxt_ir    = 1'b0;
    nxt_oe    = 1'b0;
    nxt_sup   = sup_ff;
    nxt_cdrv  = 4'hF;
    if (rep_ff != 17'h0) begin
      nxt_rep = rep_ff - 17'h1;
    end
    case (state_ff)
      irke_pkg::IRKE_IDLE: begin
        nxt_sup = 1'b0;                          // [RULE_14]
        if (any_row) begin                       // [RULE_01]
          nxt_sup   = 1'b1;
          nxt_tmr   = 17'(DEBOUNCE_CYC);
          nxt_state = irke_pkg::IRKE_DEBOUNCE;
        end
      end
      irke_pkg::IRKE_DEBOUNCE: begin
        if (tmr_ff != 17'h0) begin
          nxt_tmr = tmr_ff - 17'h1;              // [RULE_13]
          nxt_col = 2'h0;
          nxt_hit = 4'h0;
          if (tmr_ff == 17'h1) begin
            // Column 0 driven a cycle early so its rows are settled at scan
            nxt_cdrv = 4'h1;
          end
        end else begin
          // Scan one column per cycle against the column now driven
          if (col_ff != 2'h3) begin
            nxt_cdrv = 4'h1 << (col_ff + 2'h1);  // [RULE_01]
          end
          if (any_row) begin
            nxt_hit  = hit_ff | (4'h1 << col_ff);
            nxt_frm.code = key_code(col_ff, row_in);
          end
          nxt_col = col_ff + 2'h1;
          if (col_ff == 2'h3) begin
            if ((hit_ff | (any_row ? (4'h1 << col_ff) : 4'h0)) == 4'h0) begin
              nxt_state = irke_pkg::IRKE_IDLE;
            end else begin
              if ($countones(hit_ff | (any_row ? (4'h1 << col_ff) : 4'h0)) > 1) begin
                nxt_frm.code = `IRKE_END_CODE;   // [RULE_03]
              end
              nxt_frm.end_pend = 1'b0;
              nxt_slot  = 5'h0;
              nxt_tmr   = 17'(HALF_CYC - 1);
              nxt_rep   = 17'(REPEAT_CYC - 1);   // [RULE_12]
              nxt_state = irke_pkg::IRKE_SEND;
            end
          end
        end
      end
      irke_pkg::IRKE_SEND: begin
        nxt_oe  = on_phase;
        nxt_ir  = on_phase & ~car_ff;            // [RULE_09]
        nxt_car = ~car_ff;
        if (tmr_ff != 17'h0) begin
          nxt_tmr = tmr_ff - 17'h1;
        end else begin
          nxt_tmr  = 17'(HALF_CYC - 1);
          nxt_slot = slot_ff + 5'h1;
          if (slot_ff == 5'(2 * PRE_SLOTS + 13)) begin
            nxt_ir  = 1'b0;
            nxt_oe  = 1'b0;
            if (frm_ff.code == `IRKE_END_CODE) begin
              nxt_state = irke_pkg::IRKE_IDLE;   // [RULE_04]
            end else begin
              nxt_state = irke_pkg::IRKE_GAP;
            end
          end
        end
      end
      irke_pkg::IRKE_GAP: begin
        if (!any_row) begin
          nxt_frm.end_pend = 1'b1;
        end
        if (rep_ff == 17'h0) begin
          nxt_slot = 5'h0;
          nxt_tmr  = 17'(HALF_CYC - 1);
          nxt_rep  = 17'(REPEAT_CYC - 1);        // [RULE_12]
          nxt_state = irke_pkg::IRKE_SEND;
          if (frm_ff.end_pend || !any_row) begin
            nxt_frm.code = `IRKE_END_CODE;       // [RULE_04] [RULE_05]
          end
        end
      end
      default: begin
        nxt_state = irke_pkg::IRKE_IDLE;
      end
    endcase
    if (nxt_state == irke_pkg::IRKE_IDLE) begin
      nxt_sup = 1'b0;                            // [RULE_14]
    end
    if (!nxt_oe) begin
      nxt_ir = 1'b0;                             // [RULE_10]
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= irke_pkg::IRKE_IDLE;
      frm_ff   <= '0;
      tmr_ff   <= 17'h0;
      rep_ff   <= 17'h0;
      slot_ff  <= 5'h0;
      col_ff   <= 2'h0;
      hit_ff   <= 4'h0;
      car_ff   <= 1'b0;
      ir_ff    <= 1'b0;
      oe_ff    <= 1'b0;
      sup_ff   <= 1'b0;
      cdrv_ff  <= 4'hF;
    end else if (ce_in) begin
      state_ff <= nxt_state;
      frm_ff   <= nxt_frm;
      tmr_ff   <= nxt_tmr;
      rep_ff   <= nxt_rep;
      slot_ff  <= nxt_slot;
      col_ff   <= nxt_col;
      hit_ff   <= nxt_hit;
      car_ff   <= nxt_car;
      ir_ff    <= nxt_ir;
      oe_ff    <= nxt_oe;
      sup_ff   <= nxt_sup;
      cdrv_ff  <= nxt_cdrv;
    end
  end

  // Oscillator feedback: registered half-rate toggle
  logic osc_ff;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_ff <= 1'b0;
    end else if (ce_in) begin
      osc_ff <= ~osc_ff;
    end
  end

  assign column_drive_out        = cdrv_ff;
  assign infrared_drive_out      = ir_ff;
  assign infrared_drive_oe_out   = oe_ff;
  assign supply_switch_drive_out = sup_ff;
  assign oscillator_out          = osc_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rest_low;
    @(posedge clk_in) disable iff (!nrst_in)
      (state_ff != irke_pkg::IRKE_SEND) |=> !infrared_drive_out;
  endproperty
  a_rest_low: assert property (p_rest_low) else $error("ir high outside frame"); // [RULE_10]

  property p_no_rsvd;
    @(posedge clk_in) disable iff (!nrst_in)
      (state_ff == irke_pkg::IRKE_SEND) |-> (frm_ff.code != `IRKE_RSVD_CODE);
  endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved code sent"); // [RULE_06]

  property p_carrier;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
      infrared_drive_out |=> !infrared_drive_out;
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier not half rate"); // [RULE_09]

  property p_sup_idle;
    @(posedge clk_in) disable iff (!nrst_in)
      (state_ff == irke_pkg::IRKE_IDLE && !any_row) |-> !supply_switch_drive_out;
  endproperty
  a_sup_idle: assert property (p_sup_idle) else $error("supply on while idle"); // [RULE_14]

  property p_sup_wake;
    @(posedge clk_in) disable iff (!nrst_in)
      (state_ff == irke_pkg::IRKE_IDLE && any_row && ce_in) |=> supply_switch_drive_out;
  endproperty
  a_sup_wake: assert property (p_sup_wake) else $error("no wake on key"); // [RULE_01]

  property p_debounce;
    @(posedge clk_in) disable iff (!nrst_in)
      (state_ff == irke_pkg::IRKE_DEBOUNCE && tmr_ff != 17'h0)
      |=> (state_ff == irke_pkg::IRKE_DEBOUNCE);
  endproperty
  a_debounce: assert property (p_debounce) else $error("debounce cut short"); // [RULE_13]

  property p_end_last;
    @(posedge clk_in) disable iff (!nrst_in)
      (state_ff == irke_pkg::IRKE_GAP && rep_ff == 17'h0 && frm_ff.end_pend && ce_in)
      |=> (frm_ff.code == `IRKE_END_CODE);
  endproperty
  a_end_last: assert property (p_end_last) else $error("no end after release"); // [RULE_04]

  property p_end_code;
    @(posedge clk_in) disable iff (!nrst_in)
      (state_ff == irke_pkg::IRKE_SEND && $countones(hit_ff) > 1) |-> (frm_ff.code == 6'h3E);
  endproperty
  a_end_code: assert property (p_end_code) else $error("interlock failed"); // [RULE_03] [RULE_05]

  property p_pre;
    @(posedge clk_in) disable iff (!nrst_in)
      ($rose(state_ff == irke_pkg::IRKE_SEND) && ce_in) |=> infrared_drive_oe_out;
  endproperty
  a_pre: assert property (p_pre) else $error("no pre-signal"); // [RULE_11]

  c_send: cover property (@(posedge clk_in) state_ff == irke_pkg::IRKE_SEND);
  c_repeat: cover property (@(posedge clk_in)
    state_ff == irke_pkg::IRKE_GAP ##1 state_ff == irke_pkg::IRKE_SEND);
  c_end: cover property (@(posedge clk_in)
    state_ff == irke_pkg::IRKE_SEND && frm_ff.code == 6'h3E);

endmodule

// >>> core/irke_defines.svh
/*
  Constants for the infrared remote keyboard encoder: timing counts at a
  60 kHz oscillator, codes, frame layout and the start bit build-time option.
  Assumes it is included by its bare name from the core.
*/
// Function
// RULE_01: Scan four column outputs against eight row inputs; closure wakes and selects.
// RULE_02: Several rows on one column form a combined key selecting an extension code.
// RULE_03: Keys closed in two different columns send only the end instruction.
// RULE_04: After release the code goes at most once more, then one end instruction.
// RULE_05: The end instruction is code 111110, instruction 62.
// RULE_06: Code 111111, instruction 63, is never assigned nor transmitted.
// RULE_07: Each frame holds one start bit and six information bits, biphase coded.
// RULE_08: Start bit value is a build option, one by default, zero otherwise.
// RULE_09: Active output parts are keyed with a carrier at half the clock rate.
// RULE_10: With no frame in progress the infrared output rests weakly low.
// RULE_11: Each frame is preceded by a pre-signal burst for receiver gain setting.
// RULE_12: Held key frames repeat about every 120 ms; each frame lasts about 7 ms.
// RULE_13: After wake, wait about 20 ms debounce before scanning the matrix.
// RULE_14: Supply switch drive is active only while a key is active.
// RULE_15: Crossing to code is a table; basic top bit clear, pairs top bit set.
// RULE_16: Bit order, biphase polarity and pre-signal shape are parameters, MSB first.
`ifndef IRKE_DEFINES_SVH
`define IRKE_DEFINES_SVH

`define IRKE_CLK_HZ        60000
`define IRKE_DEBOUNCE_MS   20
`define IRKE_REPEAT_MS     120
`define IRKE_FRAME_MS      7
`define IRKE_DEBOUNCE_CYC  ((`IRKE_CLK_HZ * `IRKE_DEBOUNCE_MS) / 1000)
`define IRKE_REPEAT_CYC    ((`IRKE_CLK_HZ * `IRKE_REPEAT_MS) / 1000)
`define IRKE_FRAME_CYC     ((`IRKE_CLK_HZ * `IRKE_FRAME_MS) / 1000)
// Pre-signal one half-bit burst, then one half-bit gap, frame = 1+1+7*2 slots
`define IRKE_SLOTS         16
`define IRKE_HALF_CYC      (`IRKE_FRAME_CYC / `IRKE_SLOTS)
`define IRKE_END_CODE      6'h3E
`define IRKE_RSVD_CODE     6'h3F
`define IRKE_START_BIT     1'b1
`define IRKE_NCOL          4
`define IRKE_NROW          8

`endif

// >>> core/irke_pkg.sv
/*
  Types for the infrared remote keyboard encoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package irke_pkg;

  typedef enum logic [2:0] {
    IRKE_IDLE     = 3'b000,
    IRKE_DEBOUNCE = 3'b001,
    IRKE_SEND     = 3'b010,
    IRKE_GAP      = 3'b011,
    IRKE_END      = 3'b100
  } irke_state_e;

  typedef struct packed {
    logic       end_pend;
    logic [5:0] code;
  } irke_frame_s;

endpackage

// >>> verification/irke_key_matrix.sv
/*
  Key matrix model for the remote keyboard encoder bench: closed keys join
  driven columns to rows. Assumes keys_in bit col*8+row marks a closed key
  and that open rows are pulled low.
*/
`timescale 1ns/100ps

module irke_key_matrix (
  input  wire logic [3:0]  column_drive_in,
  input  wire logic [31:0] keys_in,
  output logic      [7:0]  row_out
);
  // ----------------------------------------
  // Row levels
  // ----------------------------------------
  always_comb begin
    row_out = 8'h00;
    for (int c = 0; c < 4; c++) begin
      if (column_drive_in[c]) begin
        row_out = row_out | keys_in[c*8 +: 8];
      end
    end
  end
endmodule

// >>> verification/ir_remote_keyboard_encoder_test.sv
/*
  Self-checking bench for the remote keyboard encoder: key presses, frame
  decoding, repeat, release and interlock. Assumes the key matrix model and
  shortened debounce, repeat and half-bit counts.
*/
`timescale 1ns/100ps

module ir_remote_keyboard_encoder_test;
  localparam int HC = 4;
  localparam int DB = 20;
  localparam int RP = 400;

  logic        clk_in;
  logic        nrst_in;
  logic        ce_in;
  logic [31:0] keys;
  logic [7:0]  row_in;
  logic [3:0]  col;
  logic        ir;
  logic        oe;
  logic        sup;
  logic        osc;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  irke_encoder #(.DEBOUNCE_CYC(DB), .REPEAT_CYC(RP), .HALF_CYC(HC)) irke_encoder_inst (
    .clk_in                  (clk_in),
    .nrst_in                 (nrst_in),
    .ce_in                   (ce_in),
    .row_in                  (row_in),
    .column_drive_out        (col),
    .infrared_drive_out      (ir),
    .infrared_drive_oe_out   (oe),
    .supply_switch_drive_out (sup),
    .oscillator_out          (osc)
  );

  irke_key_matrix irke_key_matrix_inst (
    .column_drive_in (col),
    .keys_in         (keys),
    .row_out         (row_in)
  );

  // ----------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------
  // Frame helpers
  // ----------------------------------------
  // Slot activity: pre burst, gap, start bit, six code bits
  function automatic logic [15:0] exp_pat(input logic [5:0] code);
    logic [15:0] p;
    p = {2'b10, 2'b01, 12'h000};
    for (int i = 0; i < 6; i++) begin
      p[11-2*i -: 2] = {~code[5-i], code[5-i]};
    end
    return p;
  endfunction

  task press(input logic [31:0] v);
    @(posedge clk_in);
    keys <= v;
    #1;
  endtask

  task get_frame(output logic [15:0] pat, output int t0);
    int   w;
    logic ir1;
    logic osc1;
    w = 0;
    pat = 16'h0000;
    ir1 = 1'b0;
    osc1 = 1'b0;
    while (oe !== 1'b1 && w < 2000) begin
      @(posedge clk_in);
      #1;
      w++;
    end
    t0 = cyc;
    for (int i = 0; i < 16*HC; i++) begin
      if (i % HC == HC/2) pat[15 - i/HC] = oe;
      if (i == 1) ir1 = ir;
      if (i == 1) osc1 = osc;
      if (i == 2) check({15'h0, ir}, {15'h0, ~ir1});
      if (i == 2) check({15'h0, osc}, {15'h0, ~osc1});
      @(posedge clk_in);
      #1;
    end
    check({15'h0, pat === exp_pat(6'h3F)}, 16'h0000);
  endtask

  task wait_off();
    int w;
    w = 0;
    while (sup !== 1'b0 && w < 1000) begin
      @(posedge clk_in);
      #1;
      w++;
    end
    check({13'h0, sup, oe, ir}, 16'h0000);
  endtask

  task release_end(input logic [5:0] c);
    logic [15:0] p;
    int          t;
    press(32'h0);
    get_frame(p, t);
    if (p === exp_pat(c)) get_frame(p, t);
    check(p, exp_pat(6'h3E));
    wait_off();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task hold_key(input logic [31:0] v, input logic [5:0] c);
    logic [15:0] p;
    int          ts;
    int          t0;
    int          t1;
    press(v);
    ts = cyc;
    get_frame(p, t0);
    check(p, exp_pat(c));
    check({15'h0, (t0 - ts) > DB}, 16'h0001);
    check({15'h0, sup}, 16'h0001);
    get_frame(p, t1);
    check(p, exp_pat(c));
    check(16'(t1 - t0), 16'(RP));
    release_end(c);
    $display("test done: key code %h", c);
  endtask

  task two_columns();
    logic [15:0] p;
    int          t;
    press(32'h0400_0001);
    get_frame(p, t);
    check(p, exp_pat(6'h3E));
    press(32'h0);
    wait_off();
    $display("test done: column interlock");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst_in = 1'b0;
    ce_in = 1'b1;
    keys = 32'h0;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      hold_key(32'h1 << (c*8 + 7 - c), {1'b0, 3'(7 - c), 2'(c)});
    end
    hold_key(32'h0041_0000, 6'h22);
    two_columns();
    print_verdict();
  end
endmodule
